//--- src/glcd_defs.svh
// Command codes, status bit positions and bus timing counts
`ifndef GLCD_DEFS_SVH
`define GLCD_DEFS_SVH
`define GLCD_OP_CURSOR   8'h21
`define GLCD_OP_OFFSET   8'h22
`define GLCD_OP_ADDR     8'h24
`define GLCD_OP_TXHOME   8'h40
`define GLCD_OP_TXAREA   8'h41
`define GLCD_OP_GRHOME   8'h42
`define GLCD_OP_GRAREA   8'h43
`define GLCD_OP_AUTO_WR  8'hB0
`define GLCD_OP_AUTO_RD  8'hB1
`define GLCD_OP_AUTO_END 8'hB2
`define GLCD_GRP_MODE    4'h8
`define GLCD_GRP_DISP    4'h9
`define GLCD_GRP_CURS    5'h14
`define GLCD_GRP_RW      5'h18
`define GLCD_GRP_BIT     4'hF
`define GLCD_ST_CMD      0
`define GLCD_ST_DAT      1
`define GLCD_ST_ARD      2
`define GLCD_ST_AWR      3
`define GLCD_ST_CTL      5
`define GLCD_ST_BLINK    7
`define GLCD_CLK_NS      50
`define GLCD_T_STROBE_NS 80
`define GLCD_T_CDS_NS    100
`define GLCD_STROBE_CYC  ((`GLCD_T_STROBE_NS + `GLCD_CLK_NS - 1) / `GLCD_CLK_NS)
`define GLCD_SETUP_CYC   ((`GLCD_T_CDS_NS + `GLCD_CLK_NS - 1) / `GLCD_CLK_NS)
`define GLCD_BUSY_CYC    2
`define GLCD_DISP_RST    4'h0
`define GLCD_CURS_RST    3'h0
`endif

//--- src/glcd_pkg.sv
// Shared types of the LCD command decoder and its host
package glcd_pkg;
   typedef logic [7:0] glcd_byte_t;
   typedef enum logic [2:0] {
      GLCD_OR   = 3'h0,
      GLCD_XOR  = 3'h1,
      GLCD_AND  = 3'h3,
      GLCD_ATTR = 3'h4
   } glcd_comb_e;
   typedef enum logic [1:0] {
      GLCD_AUTO_NONE = 2'h0,
      GLCD_AUTO_WR   = 2'h1,
      GLCD_AUTO_RD   = 2'h2
   } glcd_auto_e;
   // Gray codes along the poll, access, release path
   typedef enum logic [2:0] {
      GLCD_H_IDLE  = 3'h0,
      GLCD_H_PSET  = 3'h1,
      GLCD_H_POLL  = 3'h3,
      GLCD_H_CHECK = 3'h2,
      GLCD_H_ASET  = 3'h6,
      GLCD_H_ACC   = 3'h7,
      GLCD_H_GAP   = 3'h5
   } glcd_hstate_e;
endpackage

//--- src/glcd_bus_if.sv
// Parallel host bus between controller and microprocessor
interface glcd_bus_if;
   logic       cd;
   logic       rd_n;
   logic       wr_n;
   logic       ce_n;
   logic [7:0] host_do;
   logic       host_oe_n;
   logic [7:0] dev_do;
   logic       dev_oe_n;
   logic [7:0] db;
   // Resolved data bus level; an undriven bus floats high
   assign db = !host_oe_n ? host_do : (!dev_oe_n ? dev_do : 8'hFF);
   modport device (input cd, rd_n, wr_n, ce_n, db,
                   output dev_do, dev_oe_n);
   modport host (output cd, rd_n, wr_n, ce_n, host_do, host_oe_n,
                 input db);
endinterface

//--- src/glcd_device.sv
// Controller end: command decoder, parameter latch and display memory
`include "glcd_defs.svh"
module glcd_device #(
   parameter int MEM_AW   = 16,
   parameter int BUSY_CYC = `GLCD_BUSY_CYC
) (
   input  wire logic               clock,
   input  wire logic               resetn,
   input  wire logic               clock_en,
   glcd_bus_if.device              bus,
   output logic [7:0]              cursor_col,
   output logic [7:0]              cursor_row,
   output logic [7:0]              pattern_offset,
   output logic [15:0]             text_home,
   output logic [7:0]              text_cols,
   output logic [15:0]             graphic_home,
   output logic [7:0]              graphic_cols,
   output glcd_pkg::glcd_comb_e    combine_mode,
   output logic                    external_patterns,
   output logic [3:0]              display_enables,
   output logic [2:0]              cursor_lines,
   output glcd_pkg::glcd_auto_e    auto_mode,
   output logic [15:0]             memory_address_pointer
);
   import glcd_pkg::*;

   logic [7:0]        mem [0:(1 << MEM_AW) - 1];
   logic              wr_q;
   logic              rd_q;
   logic              rdcd_q;
   logic [7:0]        par_first;
   logic [7:0]        par_last;
   logic [7:0]        read_buf;
   logic [3:0]        busy_cnt;
   logic [7:0]        cmd;
   logic              wr_act;
   logic              rd_act;
   logic              cmd_go;
   logic              dat_go;
   logic              dat_rd_end;
   logic              is_rw;
   logic              ready;
   logic [MEM_AW-1:0] ptr_idx;
   logic [7:0]        cur_byte;
   logic              mem_we;
   logic [7:0]        mem_wd;
   logic [15:0]       next_ptr;
   logic [7:0]        status;

   // Strobes qualified by chip enable; select tells command from data
   assign wr_act     = !bus.ce_n && !bus.wr_n;
   assign rd_act     = !bus.ce_n && !bus.rd_n;
   assign cmd_go     = wr_act && !wr_q && bus.cd;
   assign dat_go     = wr_act && !wr_q && !bus.cd;
   assign dat_rd_end = rd_q && !rd_act && !rdcd_q;
   assign cmd        = bus.db;
   assign ptr_idx    = memory_address_pointer[MEM_AW-1:0];
   assign cur_byte   = mem[ptr_idx];
   assign ready      = (busy_cnt == 4'h0);
   assign is_rw      = (cmd[7:3] == `GLCD_GRP_RW) && (cmd[2:1] != 2'b11);

   // Strobe history for edge detection
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         rdcd_q <= 1'b0;
      end else if (clock_en) begin
         wr_q   <= wr_act;
         rd_q   <= rd_act;
         rdcd_q <= bus.cd;
      end
   end

   // Last two data bytes written outside auto mode are the parameters; older ones fall out
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         par_first <= 8'h00;
         par_last  <= 8'h00;
      end else if (clock_en && dat_go && auto_mode == GLCD_AUTO_NONE) begin
         par_first <= par_last;
         par_last  <= bus.db;
      end
   end

   // Busy window after each command; status reads hold off the host
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         busy_cnt <= 4'h0;
      end else if (clock_en) begin
         if (cmd_go) begin
            busy_cnt <= 4'(BUSY_CYC);
         end else if (busy_cnt != 4'h0) begin
            busy_cnt <= busy_cnt - 4'h1;
         end
      end
   end

   // Status byte: ready pairs outside auto mode, auto bits inside it
   always_comb begin
      status                 = 8'h00;
      status[`GLCD_ST_CTL]   = 1'b1;
      status[`GLCD_ST_BLINK] = 1'b1;
      if (auto_mode == GLCD_AUTO_NONE) begin
         status[`GLCD_ST_CMD] = ready;
         status[`GLCD_ST_DAT] = ready;
      end else begin
         status[`GLCD_ST_ARD] = ready && auto_mode == GLCD_AUTO_RD;
         status[`GLCD_ST_AWR] = ready && auto_mode == GLCD_AUTO_WR;
      end
   end

   // Memory write port and pointer step, decoded from the same byte
   always_comb begin
      mem_we   = 1'b0;
      mem_wd   = par_last;
      next_ptr = memory_address_pointer;
      if (dat_go && auto_mode == GLCD_AUTO_WR) begin
         mem_we   = 1'b1;
         mem_wd   = bus.db;
         next_ptr = memory_address_pointer + 16'h1;
      end else if (dat_rd_end && auto_mode == GLCD_AUTO_RD) begin
         next_ptr = memory_address_pointer + 16'h1;
      end else if (cmd_go && is_rw) begin
         mem_we = !cmd[0];
         unique case (cmd[2:1])
            2'b00:   next_ptr = memory_address_pointer + 16'h1;
            2'b01:   next_ptr = memory_address_pointer - 16'h1;
            default: next_ptr = memory_address_pointer;
         endcase
      end else if (cmd_go && cmd[7:4] == `GLCD_GRP_BIT) begin
         mem_we         = 1'b1;
         mem_wd         = cur_byte;
         mem_wd[cmd[2:0]] = cmd[3];
      end else if (cmd_go && cmd == `GLCD_OP_ADDR) begin
         next_ptr = {par_last, par_first};
      end
   end

   // Display memory has no reset; contents are software's business
   always_ff @(posedge clock) begin
      if (clock_en && mem_we) begin
         mem[ptr_idx] <= mem_wd;
      end
   end

   // Address pointer
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         memory_address_pointer <= 16'h0000;
      end else if (clock_en) begin
         memory_address_pointer <= next_ptr;
      end
   end

   // Read buffer: loaded by read commands and refilled in auto read
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         read_buf <= 8'h00;
      end else if (clock_en) begin
         if (cmd_go && is_rw && cmd[0]) begin
            read_buf <= cur_byte;
         end else if (cmd_go && cmd == `GLCD_OP_AUTO_RD) begin
            read_buf <= cur_byte;
         end else if (auto_mode == GLCD_AUTO_RD && !rd_act) begin
            read_buf <= cur_byte;
         end
      end
   end

   // Pointer and area registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cursor_col     <= 8'h00;
         cursor_row     <= 8'h00;
         pattern_offset <= 8'h00;
         text_home      <= 16'h0000;
         text_cols      <= 8'h00;
         graphic_home   <= 16'h0000;
         graphic_cols   <= 8'h00;
      end else if (clock_en && cmd_go) begin
         unique case (cmd)
            `GLCD_OP_CURSOR: begin
               cursor_col <= par_first;
               cursor_row <= par_last;
            end
            `GLCD_OP_OFFSET: pattern_offset <= par_first;
            `GLCD_OP_TXHOME: text_home <= {par_last, par_first};
            `GLCD_OP_TXAREA: text_cols <= par_first;
            `GLCD_OP_GRHOME: graphic_home <= {par_last, par_first};
            `GLCD_OP_GRAREA: graphic_cols <= par_first;
            default: ;
         endcase
      end
   end

   // Mode, display and cursor shape; undefined combine codes are dropped
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         combine_mode      <= GLCD_OR;
         external_patterns <= 1'b0;
         display_enables   <= `GLCD_DISP_RST;
         cursor_lines      <= `GLCD_CURS_RST;
      end else if (clock_en && cmd_go) begin
         if (cmd[7:4] == `GLCD_GRP_MODE &&
             cmd[2:0] inside {3'h0, 3'h1, 3'h3, 3'h4}) begin
            combine_mode      <= glcd_comb_e'(cmd[2:0]);
            external_patterns <= cmd[3];
         end
         if (cmd[7:4] == `GLCD_GRP_DISP) begin
            // 90h clears all four, turning everything off
            display_enables <= cmd[3:0];
         end
         if (cmd[7:3] == `GLCD_GRP_CURS) begin
            cursor_lines <= cmd[2:0];
         end
      end
   end

   // Auto mode entry and exit
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         auto_mode <= GLCD_AUTO_NONE;
      end else if (clock_en && cmd_go) begin
         if (cmd == `GLCD_OP_AUTO_WR) begin
            auto_mode <= GLCD_AUTO_WR;
         end else if (cmd == `GLCD_OP_AUTO_RD) begin
            auto_mode <= GLCD_AUTO_RD;
         end else if (cmd == `GLCD_OP_AUTO_END) begin
            auto_mode <= GLCD_AUTO_NONE;
         end
      end
   end

   // Read drive is registered: data appears one edge after the strobe
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bus.dev_do   <= 8'h00;
         bus.dev_oe_n <= 1'b1;
      end else if (clock_en) begin
         bus.dev_oe_n <= !rd_act;
         bus.dev_do   <= bus.cd ? status : read_buf;
      end
   end
endmodule // glcd_device

//--- src/glcd_host.sv
// Host end: one bus transfer per user request, after a status poll except for status reads
`include "glcd_defs.svh"
module glcd_host #(
   parameter int STROBE_CYC = `GLCD_STROBE_CYC,
   parameter int SETUP_CYC  = `GLCD_SETUP_CYC
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        clock_en,
   glcd_bus_if.host         bus,
   input  wire logic        req_valid,
   input  wire logic        req_cd,
   input  wire logic        req_read,
   input  wire logic [7:0]  req_data,
   output logic             req_ready,
   output logic             resp_valid,
   output logic [7:0]       resp_data
);
   import glcd_pkg::*;

   glcd_hstate_e state;
   logic [3:0]   cnt;
   logic         r_cd;
   logic         r_read;
   logic [7:0]   r_data;
   glcd_auto_e   auto_seen;
   logic         stat_ok;
   logic         last_cnt;

   assign last_cnt = (cnt == 4'h0);

   // Auto mode needs its own ready bit instead of the usual pair
   always_comb begin
      if (auto_seen == GLCD_AUTO_WR) begin
         stat_ok = bus.db[`GLCD_ST_AWR];
      end else if (auto_seen == GLCD_AUTO_RD) begin
         stat_ok = bus.db[`GLCD_ST_ARD];
      end else begin
         stat_ok = bus.db[`GLCD_ST_CMD] && bus.db[`GLCD_ST_DAT];
      end
   end

   // Sequencer; status reads themselves skip the poll
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state  <= GLCD_H_IDLE;
         cnt    <= 4'h0;
         r_cd   <= 1'b0;
         r_read <= 1'b0;
         r_data <= 8'h00;
      end else if (clock_en) begin
         if (!last_cnt) begin
            cnt <= cnt - 4'h1;
         end
         unique case (state)
            GLCD_H_IDLE: if (req_valid) begin
               r_cd   <= req_cd;
               r_read <= req_read;
               r_data <= req_data;
               cnt    <= 4'(SETUP_CYC - 1);
               state  <= (req_cd && req_read) ? GLCD_H_ASET : GLCD_H_PSET;
            end
            GLCD_H_PSET: if (last_cnt) begin
               cnt   <= 4'(STROBE_CYC - 1);
               state <= GLCD_H_POLL;
            end
            GLCD_H_POLL: if (last_cnt) begin
               state <= GLCD_H_CHECK;
            end
            GLCD_H_CHECK: begin
               cnt   <= 4'(SETUP_CYC - 1);
               state <= stat_ok ? GLCD_H_ASET : GLCD_H_PSET;
            end
            GLCD_H_ASET: if (last_cnt) begin
               cnt   <= 4'(STROBE_CYC - 1);
               state <= GLCD_H_ACC;
            end
            GLCD_H_ACC: if (last_cnt) begin
               state <= GLCD_H_GAP;
            end
            GLCD_H_GAP: state <= GLCD_H_IDLE;
         endcase
      end
   end

   // Track auto mode from the commands this end sends
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         auto_seen <= GLCD_AUTO_NONE;
      end else if (clock_en && state == GLCD_H_GAP && r_cd && !r_read) begin
         if (r_data == `GLCD_OP_AUTO_WR) begin
            auto_seen <= GLCD_AUTO_WR;
         end else if (r_data == `GLCD_OP_AUTO_RD) begin
            auto_seen <= GLCD_AUTO_RD;
         end else if (r_data == `GLCD_OP_AUTO_END) begin
            auto_seen <= GLCD_AUTO_NONE;
         end
      end
   end

   // Bus pins; select is set up ahead of the strobe and held past it
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bus.cd        <= 1'b1;
         bus.rd_n      <= 1'b1;
         bus.wr_n      <= 1'b1;
         bus.ce_n      <= 1'b1;
         bus.host_do   <= 8'h00;
         bus.host_oe_n <= 1'b1;
      end else if (clock_en) begin
         bus.ce_n <= !(state == GLCD_H_PSET || state == GLCD_H_POLL ||
                       state == GLCD_H_ASET || state == GLCD_H_ACC);
         // Select moves at the poll verdict, two clocks before the strobe
         bus.cd   <= (state == GLCD_H_ASET || state == GLCD_H_ACC ||
                      (state == GLCD_H_CHECK && stat_ok)) ?
                     r_cd : 1'b1;
         bus.rd_n <= !((state == GLCD_H_PSET && last_cnt) ||
                       (state == GLCD_H_POLL && !last_cnt) ||
                       (state == GLCD_H_ASET && last_cnt && r_read) ||
                       (state == GLCD_H_ACC && !last_cnt && r_read));
         bus.wr_n <= !((state == GLCD_H_ASET && last_cnt && !r_read) ||
                       (state == GLCD_H_ACC && !last_cnt && !r_read));
         bus.host_do   <= r_data;
         bus.host_oe_n <= !((state == GLCD_H_ASET || state == GLCD_H_ACC)
                            && !r_read);
      end
   end

   // User side answer
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         req_ready  <= 1'b0;
         resp_valid <= 1'b0;
         resp_data  <= 8'h00;
      end else if (clock_en) begin
         req_ready  <= (state == GLCD_H_IDLE && !req_valid) ||
                       state == GLCD_H_GAP;
         resp_valid <= (state == GLCD_H_ACC && last_cnt);
         if (state == GLCD_H_ACC && last_cnt && r_read) begin
            resp_data <= bus.db;
         end
      end
   end
endmodule // glcd_host

//--- dv/glcd_monitor.sv
// Bus checker for the parallel port between host and controller
module glcd_monitor (
   input wire logic       clock,
   input wire logic       resetn,
   input wire logic       cd,
   input wire logic       rd_n,
   input wire logic       wr_n,
   input wire logic       ce_n,
   input wire logic [7:0] host_do,
   input wire logic       host_oe_n,
   input wire logic [7:0] dev_do,
   input wire logic       dev_oe_n,
   input wire logic [7:0] db
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   // Phases of one strobe; a read needs two low samples before data is due
   sequence s_wr_start;
      $fell(wr_n);
   endsequence
   sequence s_rd_held;
      (!rd_n && !ce_n)[*2];
   endsequence

   // Two drivers on the data bus would short the lines
   a_one_bus_driver: assert property (host_oe_n || dev_oe_n)
      else $error("host and controller drive the bus together");
   a_strobe_in_ce: assert property ((!rd_n || !wr_n) |-> !ce_n)
      else $error("strobe active without chip enable");
   a_single_strobe: assert property (rd_n || wr_n)
      else $error("read and write strobes low together");
   a_write_drives: assert property (
      s_wr_start |-> !host_oe_n && db == host_do)
      else $error("write strobe without host data on the bus");
   // Strobe lasts at least two clocks, select settled two clocks before
   a_write_width: assert property (s_wr_start |=> !wr_n)
      else $error("write strobe shorter than two clocks");
   a_cd_setup: assert property (s_wr_start |-> cd == $past(cd, 2))
      else $error("select changed too close to write strobe");
   a_cd_hold: assert property ($rose(wr_n) |-> $stable(cd))
      else $error("select changed with the end of the strobe");
   a_data_hold: assert property ($rose(wr_n) |-> !host_oe_n)
      else $error("host released data with the end of the strobe");
   a_read_answer: assert property (
      s_rd_held |-> !dev_oe_n && db == dev_do)
      else $error("controller not driving a held read");
   a_reset_idle: assert property (
      $rose(resetn) |-> ce_n && rd_n && wr_n && host_oe_n)
      else $error("bus not idle after reset release");
endmodule // glcd_monitor

//--- dv/tb.sv
// Testbench: host and controller joined over the parallel port
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import glcd_pkg::*;
   logic        clock;
   logic        resetn;
   logic        req_valid;
   logic        req_cd;
   logic        req_read;
   logic [7:0]  req_data;
   logic        req_ready;
   logic        resp_valid;
   logic [7:0]  resp_data;
   logic [7:0]  ccol, crow, poff, tcols, gcols;
   logic [15:0] thome, ghome, ptr;
   glcd_comb_e  comb;
   glcd_auto_e  amode;
   logic        extp;
   logic [3:0]  dena;
   logic [2:0]  clines;
   int          err_count = 0;
   int          checked = 0;

   glcd_bus_if i_glcd_bus_if ();
   glcd_device #(.MEM_AW(8)) i_glcd_device (.clock(clock),
      .resetn(resetn), .clock_en(1'b1), .bus(i_glcd_bus_if.device),
      .cursor_col(ccol), .cursor_row(crow), .pattern_offset(poff),
      .text_home(thome), .text_cols(tcols), .graphic_home(ghome),
      .graphic_cols(gcols), .combine_mode(comb), .external_patterns(extp),
      .display_enables(dena), .cursor_lines(clines), .auto_mode(amode),
      .memory_address_pointer(ptr));
   glcd_host i_glcd_host (.clock(clock), .resetn(resetn), .clock_en(1'b1),
      .bus(i_glcd_bus_if.host), .req_valid(req_valid), .req_cd(req_cd),
      .req_read(req_read), .req_data(req_data), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp_data(resp_data));
   glcd_monitor i_glcd_monitor (.clock(clock), .resetn(resetn),
      .cd(i_glcd_bus_if.cd), .rd_n(i_glcd_bus_if.rd_n),
      .wr_n(i_glcd_bus_if.wr_n), .ce_n(i_glcd_bus_if.ce_n),
      .host_do(i_glcd_bus_if.host_do), .host_oe_n(i_glcd_bus_if.host_oe_n),
      .dev_do(i_glcd_bus_if.dev_do), .dev_oe_n(i_glcd_bus_if.dev_oe_n),
      .db(i_glcd_bus_if.db));

   // Free-running 20 MHz clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One user request; held until taken, then wait for the answer
   task automatic xfer(input logic c, input logic r, input logic [7:0] d,
                       output logic [7:0] q);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_cd = c;
      req_read = r;
      req_data = d;
      while (req_ready !== 1'b1 && n < 400) begin
         @(posedge clock) #2;
         n++;
      end
      @(posedge clock) #2;
      req_valid = 1'b0;
      while (resp_valid !== 1'b1 && n < 400) begin
         @(posedge clock) #2;
         n++;
      end
      if (n >= 400) chk(16'h0000, 16'h0001);
      q = resp_data;
      @(posedge clock) #2;
   endtask

   task automatic wr(input logic c, input logic [7:0] d);
      logic [7:0] q;
      xfer(c, 1'b0, d, q);
   endtask
   task automatic rd(input logic c, output logic [7:0] q);
      xfer(c, 1'b1, 8'h00, q);
   endtask
   // Parameters always go first, the command byte last
   task automatic cmd2(input logic [7:0] op, d1, d2);
      wr(1'b0, d1);
      wr(1'b0, d2);
      wr(1'b1, op);
   endtask
   task automatic wcmd(input logic [7:0] op, d);
      wr(1'b0, d);
      wr(1'b1, op);
   endtask
   task automatic rcmd(input logic [7:0] op, output logic [7:0] q);
      wr(1'b1, op);
      rd(1'b0, q);
   endtask

   // Pointer and area setters, with a stale byte ahead of one pair
   task automatic t_registers;
      wr(1'b0, 8'h77);
      cmd2(8'h21, 8'h12, 8'h34);
      chk({crow, ccol}, 16'h3412);
      cmd2(8'h22, 8'h05, 8'h00);
      chk({8'h00, poff}, 16'h0005);
      cmd2(8'h24, 8'hCD, 8'hAB);
      chk(ptr, 16'hABCD);
      cmd2(8'h40, 8'h00, 8'h10);
      cmd2(8'h41, 8'h1E, 8'h00);
      chk(thome, 16'h1000);
      chk({8'h00, tcols}, 16'h001E);
      cmd2(8'h42, 8'h00, 8'h20);
      cmd2(8'h43, 8'h28, 8'h00);
      chk(ghome, 16'h2000);
      chk({8'h00, gcols}, 16'h0028);
   endtask

   // Every combine code with both pattern sources, then bad codes
   task automatic t_modes;
      logic [2:0]  codes [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
      logic [15:0] keep;
      for (int i = 0; i < 8; i++) begin
         wr(1'b1, {4'h8, i[0], codes[i / 2]});
         chk({13'h0000, comb}, {13'h0000, codes[i / 2]});
         chk({15'h0000, extp}, {15'h0000, i[0]});
      end
      keep = ptr;
      wr(1'b1, 8'h82);
      wr(1'b1, 8'hE0);
      wr(1'b1, 8'hC7);
      chk({12'h000, extp, comb}, 16'h000C);
      chk(ptr, keep);
   endtask

   // All display enables, ending on all-off, and all cursor heights
   task automatic t_display;
      for (int i = 15; i >= 0; i--) begin
         wr(1'b1, {4'h9, i[3:0]});
         chk({12'h000, dena}, {12'h000, i[3:0]});
      end
      for (int i = 0; i < 8; i++) begin
         wr(1'b1, {5'h14, i[2:0]});
         chk({13'h0000, clines}, {13'h0000, i[2:0]});
      end
   endtask

   // Single transfers with each pointer step, then bit changes
   task automatic t_single;
      logic [7:0] q;
      cmd2(8'h24, 8'h10, 8'h00);
      wcmd(8'hC0, 8'h5A);
      chk(ptr, 16'h0011);
      wcmd(8'hC2, 8'hA5);
      chk(ptr, 16'h0010);
      wcmd(8'hC4, 8'h3C);
      chk(ptr, 16'h0010);
      rcmd(8'hC5, q);
      chk({q, ptr[7:0]}, 16'h3C10);
      rcmd(8'hC1, q);
      chk({q, ptr[7:0]}, 16'h3C11);
      rcmd(8'hC3, q);
      chk({q, ptr[7:0]}, 16'hA510);
      wr(1'b1, 8'hFF);
      wr(1'b1, 8'hF2);
      wr(1'b1, 8'hF8);
      rcmd(8'hC5, q);
      chk({8'h00, q}, 16'h00B9);
   endtask

   // Auto write then auto read of the same two bytes, status per mode
   task automatic t_auto;
      logic [7:0] q;
      rd(1'b1, q);
      chk({14'h0000, q[1:0]}, 16'h0003);
      cmd2(8'h24, 8'h20, 8'h00);
      wr(1'b1, 8'hB0);
      rd(1'b1, q);
      chk({amode, 10'h000, q[3:0]}, 16'h4008);
      wr(1'b0, 8'h11);
      wr(1'b0, 8'h22);
      wr(1'b1, 8'hB2);
      chk({amode, ptr[13:0]}, 16'h0022);
      cmd2(8'h24, 8'h20, 8'h00);
      wr(1'b1, 8'hB1);
      rd(1'b1, q);
      chk({amode, 10'h000, q[3:0]}, 16'h8004);
      rd(1'b0, q);
      chk({8'h00, q}, 16'h0011);
      rd(1'b0, q);
      chk({8'h00, q}, 16'h0022);
      wr(1'b1, 8'hB2);
      chk({14'h0000, amode}, 16'h0000);
   endtask

   task automatic tally_and_finish;
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Hang guard, far beyond the thousand or so clocks the tests take
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      tally_and_finish();
   end

   // Reset, then the scenarios in turn
   initial begin
      resetn = 1'b0;
      req_valid = 1'b0;
      req_cd = 1'b0;
      req_read = 1'b0;
      req_data = 8'h00;
      repeat (20) @(posedge clock);
      #2 resetn = 1'b1;
      @(posedge clock) #2;
      t_registers();
      t_modes();
      t_display();
      t_single();
      t_auto();
      tally_and_finish();
   end
endmodule // tb
